// ===== rtl/measurement_trigger_control.sv
// Measurement trigger control: trigger input, field-bus trigger, encoder
// pacing and setup-load handshake, with an Avalon-MM register slave.
// Assumes the measuring engine answers meas_start with one meas_done pulse.
`timescale 1ns/1ns

module measurement_trigger_control
    import trig_pkg::*;
(
    input wire logic mclk, // 100 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte enables
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic trigger_in, // Trigger pin, from outside
    input wire logic encoder_channel_a, // Encoder channel A pin
    input wire logic encoder_channel_b, // Encoder channel B pin
    input wire logic encoder_reference, // Once-per-turn pulse, unused
    input wire logic config_locked, // Another session holds the setups
    output logic meas_start, // One-cycle start to measuring engine
    input wire logic meas_done, // One-cycle done from measuring engine
    input wire logic [31:0] meas_value, // Value with meas_done
    output logic [31:0] result_value, // Held measured value
    output logic outputs_frozen, // Output functions frozen
    output logic laser_reduced, // Laser at reduced power
    output logic [15:0] active_setup // Currently loaded setup index
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [2:0] trig_sync;
    logic [2:0] enc_a_sync;
    logic [2:0] enc_b_sync;
    logic trig_level;
    logic enc_a_level;
    logic enc_b_level;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trig_sync <= 3'h0;
            enc_a_sync <= 3'h0;
            enc_b_sync <= 3'h0;
        end else begin
            trig_sync <= {trig_sync[1:0], trigger_in};
            enc_a_sync <= {enc_a_sync[1:0], encoder_channel_a};
            enc_b_sync <= {enc_b_sync[1:0], encoder_channel_b};
        end
    end

    // A level changes only when stages two and three agree
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trig_level <= 1'b0;
            enc_a_level <= 1'b0;
            enc_b_level <= 1'b0;
        end else begin
            if (trig_sync[1] == trig_sync[2]) begin
                trig_level <= trig_sync[2];
            end
            if (enc_a_sync[1] == enc_a_sync[2]) begin
                enc_a_level <= enc_a_sync[2];
            end
            if (enc_b_sync[1] == enc_b_sync[2]) begin
                enc_b_level <= enc_b_sync[2];
            end
        end
    end

    wire trig_fall = trig_level && (trig_sync[1] == trig_sync[2]) && !trig_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0] mode;
    logic laser_on;
    logic [31:0] interval;
    logic [15:0] step_width;
    logic [15:0] selector;
    logic [15:0] argument;
    logic load_done;
    logic load_error;
    logic [15:0] ret_arg;
    logic trig_pend;
    logic [31:0] enc_pos;
    logic enc_dir;
    logic [15:0] step_cnt;
    logic [31:0] int_cnt;
    logic [12:0] low_cnt;
    meas_state_t state;
    logic [15:0] delay_cnt;

    wire trig_mode_t cur_mode = trig_mode_t'(mode);
    wire wr = avs_write;
    wire rd = avs_read;
    wire sel_ctrl = (avs_address == ADDR_CTRL);
    wire sel_int = (avs_address == ADDR_INTERVAL);
    wire sel_step = (avs_address == ADDR_STEP);
    wire sel_sel = (avs_address == ADDR_SEL);
    wire sel_arg = (avs_address == ADDR_ARG);
    wire sel_pstat = (avs_address == ADDR_PSTAT);
    wire wr_ctrl = wr && sel_ctrl && avs_byteenable[0];
    // Software trigger acts in single mode only; repeat modes pace themselves
    wire sw_trig = wr_ctrl && avs_writedata[CTRL_SW_TRIG];
    wire load_req = wr_ctrl && avs_writedata[CTRL_LOAD_REQ];
    wire step_ok = ({avs_writedata[15:8], avs_writedata[7:0]} >= MIN_STEP);
    wire is_load = (selector == 16'h0000);
    wire load_fail = config_locked || (argument >= SETUP_COUNT);
    wire load_ok = load_req && is_load && !load_fail;
    wire load_bad = load_req && !load_ok;

    // Slave answers in the request cycle; no wait states
    assign avs_waitrequest = 1'b0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode <= MODE_SINGLE;
            laser_on <= 1'b0;
            interval <= RESET_INTERVAL;
            step_width <= RESET_STEP;
            selector <= 16'h0000;
            argument <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                mode <= avs_writedata[CTRL_MODE_LSB +: 2];
                laser_on <= avs_writedata[CTRL_LASER_ON];
            end
            if (wr && sel_int) begin
                interval <= avs_writedata;
            end
            if (wr && sel_step && step_ok) begin
                step_width <= avs_writedata[15:0];
            end
            if (wr && sel_sel) begin
                selector <= avs_writedata[15:0];
            end
            if (wr && sel_arg) begin
                argument <= avs_writedata[15:0];
            end
        end
    end

    // Setup load handshake; a fresh request clears the old flags
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            load_done <= 1'b0;
            load_error <= 1'b0;
            ret_arg <= 16'h0000;
            active_setup <= 16'h0000;
        end else if (load_req) begin
            load_done <= load_ok;
            load_error <= load_bad;
            if (load_ok) begin
                active_setup <= argument;
                ret_arg <= argument;
            end else if (!is_load) begin
                ret_arg <= ERR_BAD_SELECTOR;
            end else if (config_locked) begin
                ret_arg <= ERR_BLOCKED;
            end else begin
                ret_arg <= ERR_BAD_SETUP;
            end
        end else if (wr && sel_pstat) begin
            load_done <= 1'b0;
            load_error <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Encoder: quadrature decode, every edge counts unless A and B change in the same cycle
    logic enc_a_prev;
    logic enc_b_prev;
    wire a_edge = enc_a_level ^ enc_a_prev;
    wire b_edge = enc_b_level ^ enc_b_prev;
    // Forward when A leads B
    wire dir_fwd = a_edge ? (enc_a_level != enc_b_level) : (enc_a_level == enc_b_level);
    // Both channels count, so one encoder line gives four steps
    wire enc_step = a_edge ^ b_edge;
    // encoder_reference is never read: the reference pulse plays no part
    wire step_hit = enc_step && (step_cnt >= step_width - 16'h0001);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            enc_a_prev <= 1'b0;
            enc_b_prev <= 1'b0;
            enc_pos <= 32'h00000000;
            enc_dir <= 1'b0;
            step_cnt <= 16'h0000;
        end else begin
            enc_a_prev <= enc_a_level;
            enc_b_prev <= enc_b_level;
            if (enc_step) begin
                enc_dir <= dir_fwd;
                enc_pos <= dir_fwd ? enc_pos + 32'h00000001 : enc_pos - 32'h00000001;
                step_cnt <= step_hit ? 16'h0000 : step_cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pending and pacing
    wire single = (cur_mode == MODE_SINGLE);
    wire paused = trig_level;
    wire int_hit = (int_cnt >= interval);
    wire low_ok = (low_cnt >= 13'(LOW_MIN_CYC));
    wire ext_evt = single && trig_fall && low_ok;
    wire rep_evt = !single && !paused && (
        (cur_mode == MODE_CONTINUOUS) ||
        (cur_mode == MODE_INTERVAL && int_hit) ||
        (cur_mode == MODE_ENCODER && step_hit));
    wire take = (state == ST_HOLD) && trig_pend && laser_on;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            low_cnt <= 13'h0000;
            int_cnt <= 32'h00000000;
        end else begin
            // Low time is held while the pin is high and judged at the next fall;
            // clearing it on the rising side would refuse every pulse
            if (trig_fall) begin
                low_cnt <= 13'h0000;
            end else if (!trig_level && !low_ok) begin
                low_cnt <= low_cnt + 13'h0001;
            end
            int_cnt <= (int_hit || cur_mode != MODE_INTERVAL) ? 32'h00000000
                : int_cnt + 32'h00000001;
        end
    end

    // Set wins over the clear when both fall in one cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trig_pend <= 1'b0;
        end else if (ext_evt || (sw_trig && single) || rep_evt) begin
            trig_pend <= laser_on;
        end else if (take || !laser_on) begin
            trig_pend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    wire delay_end = (delay_cnt == 16'h0000);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= ST_HOLD;
            delay_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_HOLD: begin
                    if (take) begin
                        state <= ST_DELAY;
                        delay_cnt <= 16'h0000;
                    end
                end
                ST_DELAY: begin
                    if (delay_end) begin
                        state <= ST_MEASURE;
                    end else begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end
                end
                ST_MEASURE: begin
                    if (meas_done) begin
                        state <= ST_HOLD;
                    end
                end
                default: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // Start leaves within one cycle of the pending check, well under the limit
    assign meas_start = (state == ST_DELAY) && delay_end;
    assign laser_reduced = (state == ST_HOLD);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            result_value <= 32'h00000000;
            outputs_frozen <= 1'b0;
        end else begin
            if (meas_done && state == ST_MEASURE) begin
                result_value <= meas_value;
            end
            if (single && trig_level) begin
                outputs_frozen <= 1'b1;
            end else if (meas_done && state == ST_MEASURE) begin
                outputs_frozen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    // Unmapped addresses read as zero so software can probe the map safely
    wire [31:0] rd_ctrl = {27'h0000000, 1'b0, 1'b0, laser_on, mode};
    wire [31:0] rd_status = {27'h0000000, outputs_frozen, enc_dir, trig_pend, state};
    wire [31:0] rd_pstat = {29'h00000000, load_error, 1'b0, load_done};
    wire [31:0] rd_mux =
        sel_ctrl ? rd_ctrl :
        sel_int ? interval :
        sel_step ? {16'h0000, step_width} :
        (avs_address == ADDR_STATUS) ? rd_status :
        (avs_address == ADDR_RESULT) ? result_value :
        (avs_address == ADDR_ENC_POS) ? enc_pos :
        sel_sel ? {16'h0000, selector} :
        sel_arg ? {16'h0000, argument} :
        sel_pstat ? rd_pstat :
        (avs_address == ADDR_RET_ARG) ? {16'h0000, ret_arg} : 32'h00000000;

    // Read data is combinational so it stands at the zero-wait edge
    assign avs_readdata = rd ? rd_mux : 32'h00000000;

endmodule // measurement_trigger_control

// ===== rtl/trig_pkg.sv
// Package for the measurement trigger control block.
// Assumes a single 100 MHz clock domain and an Avalon-MM register slave.
package trig_pkg;
    localparam int CLK_MHZ = 100;
    localparam int TRIG_DELAY_US = 25;
    localparam int LOW_MIN_US = 25;
    // Longest time rounds down, least time rounds up
    localparam int TRIG_DELAY_CYC = (TRIG_DELAY_US * CLK_MHZ) - 1;
    localparam int LOW_MIN_CYC = LOW_MIN_US * CLK_MHZ;
    localparam logic [15:0] MIN_STEP = 16'h0003;

    // Register byte addresses (word aligned)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_STEP = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_ENC_POS = 8'h14;
    localparam logic [7:0] ADDR_SEL = 8'h18;
    localparam logic [7:0] ADDR_ARG = 8'h1c;
    localparam logic [7:0] ADDR_PSTAT = 8'h20;
    localparam logic [7:0] ADDR_RET_ARG = 8'h24;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LASER_ON = 2;
    localparam int CTRL_SW_TRIG = 3;
    localparam int CTRL_LOAD_REQ = 4;

    // Parameterization status bits
    localparam int PSTAT_DONE = 0;
    localparam int PSTAT_ERROR = 2;

    localparam logic [15:0] ERR_BLOCKED = 16'h0001;
    localparam logic [15:0] ERR_BAD_SETUP = 16'h0002;
    localparam logic [15:0] ERR_BAD_SELECTOR = 16'h0003;
    localparam logic [15:0] SETUP_COUNT = 16'h0004;

    localparam logic [31:0] RESET_INTERVAL = 32'h000003e8;
    localparam logic [15:0] RESET_STEP = 16'h0003;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_CONTINUOUS = 2'b01,
        MODE_INTERVAL = 2'b10,
        MODE_ENCODER = 2'b11
    } trig_mode_t;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_MEASURE = 2'b10
    } meas_state_t;
endpackage

// ===== sim/mtc_properties.sv
// Checker for the trigger control block: bus answers, start/done and held result.
// Assumes only the block's own ports; attached by bind at the foot.
`timescale 1ns/1ns
module mtc_properties
    import trig_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic [7:0] avs_address, // Bus address
    input wire logic avs_read, // Bus read
    input wire logic [31:0] avs_readdata, // Bus read data
    input wire logic avs_waitrequest, // Bus stall
    input wire logic meas_start, // Start to engine
    input wire logic meas_done, // Done from engine
    input wire logic [31:0] meas_value, // Engine value
    input wire logic [31:0] result_value, // Held result
    input wire logic laser_reduced // Laser at low power
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // Open engine cycle, so a stray done is never taken as a fresh one
    logic busy;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else if (meas_start) begin
            busy <= 1'b1;
        end else if (meas_done) begin
            busy <= 1'b0;
        end
    end
    ////////////////////////////////////////
    a_start_one_cycle: assert property (meas_start |=> !meas_start)
        else $error("start pulse longer than one cycle");
    a_no_restart_busy: assert property (meas_start |-> !busy)
        else $error("start while a measurement runs");
    a_start_from_hold: assert property (meas_start |-> $past(laser_reduced))
        else $error("start not preceded by hold");
    a_start_leaves_hold: assert property (meas_start |-> !laser_reduced)
        else $error("laser still reduced at start");
    a_done_back_hold: assert property (meas_done && busy |=> laser_reduced)
        else $error("no reduced power after done");
    a_result_loads: assert property (meas_done && busy |=> result_value == $past(meas_value))
        else $error("result not loaded from done value");
    a_result_held: assert property ($changed(result_value) |-> $past(meas_done))
        else $error("result changed without done");
    a_no_wait_state: assert property (!avs_waitrequest)
        else $error("waitrequest raised");
    a_idle_read_zero: assert property (!avs_read |-> avs_readdata == 32'h0)
        else $error("read data without read");
    a_unmapped_zero: assert property (avs_read && avs_address > ADDR_RET_ARG |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // mtc_properties

bind measurement_trigger_control mtc_properties chk (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .meas_start(meas_start), .meas_done(meas_done),
    .meas_value(meas_value), .result_value(result_value), .laser_reduced(laser_reduced));

// ===== sim/far_side_model.sv
// Far side: measuring engine answering each start, and a two-channel encoder.
// Assumes the bench pulses step_go for one cycle per wanted encoder edge.
`timescale 1ns/1ns
module far_side_model (
    input wire logic mclk, // Clock
    input wire logic meas_start, // Start from the block
    input wire logic [7:0] lag, // Cycles from start to done
    input wire logic step_go, // One encoder edge wanted
    input wire logic step_dir, // Edge direction
    output logic meas_done, // Done pulse
    output logic [31:0] meas_value, // Value, valid with done only
    output logic encoder_channel_a, // Encoder channel A
    output logic encoder_channel_b // Encoder channel B
);
    int seed = 71581;
    int left = -1;
    logic [1:0] phase = 2'b00;
    // Done fires once the lag has run out and no fresh start arrives
    wire fire = (meas_start !== 1'b1) && (left == 0);
    initial meas_done = 1'b0;
    initial meas_value = 32'h0;
    // Gray order: one channel moves per step, so edges alternate
    assign encoder_channel_a = phase[0];
    assign encoder_channel_b = phase[1];
    always @(posedge mclk) begin
        meas_done <= fire;
        // Value wanders outside the done cycle so a late sample shows up
        meas_value <= fire ? $random(seed) : ~meas_value;
        if (meas_start === 1'b1) begin
            left <= lag;
        end else if (left == 0) begin
            left <= -1;
        end else if (left > 0) begin
            left <= left - 1;
        end
        if (step_go) begin
            phase <= step_dir ? {~phase[0], phase[1]} : {phase[0], ~phase[1]};
        end
    end
endmodule // far_side_model

// ===== sim/testbench.sv
// Self-checking bench for the trigger control block.
// Assumes trig_pkg, the far-side model and the bound checker are compiled first.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
    import trig_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic trigger_in = 1'b0;
    logic encoder_reference = 1'b0;
    logic config_locked = 1'b0;
    logic step_go = 1'b0;
    logic step_dir = 1'b0;
    logic rd_ev = 1'b0;
    logic [7:0] lag = 8'h01;
    logic [31:0] avs_readdata, meas_value, result_value, rd_seen, last_val, e, p0, got;
    logic avs_waitrequest, meas_start, meas_done, outputs_frozen, laser_reduced;
    logic encoder_channel_a, encoder_channel_b;
    logic [15:0] active_setup;
    logic [31:0] ld_arg[4] = '{32'h2, 32'h1, 32'h4, 32'h1};
    logic [31:0] ld_st[4] = '{32'h1, 32'h4, 32'h4, 32'h4};
    logic [31:0] ld_ret[4] = '{32'h2, 32'h1, 32'h2, 32'h3};
    logic [31:0] exp_q[$];
    string name_q[$];
    string n;
    int fail_count = 0;
    int num_checks = 0;
    int starts = 0;
    int seed = 71581;
    int s0, iv;
    always #5 mclk = ~mclk;
    measurement_trigger_control dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trigger_in(trigger_in), .encoder_channel_a(encoder_channel_a),
        .encoder_channel_b(encoder_channel_b), .encoder_reference(encoder_reference),
        .config_locked(config_locked), .meas_start(meas_start), .meas_done(meas_done),
        .meas_value(meas_value), .result_value(result_value), .outputs_frozen(outputs_frozen),
        .laser_reduced(laser_reduced), .active_setup(active_setup));
    far_side_model far (.mclk(mclk), .meas_start(meas_start), .lag(lag), .step_go(step_go),
        .step_dir(step_dir), .meas_done(meas_done), .meas_value(meas_value),
        .encoder_channel_a(encoder_channel_a), .encoder_channel_b(encoder_channel_b));
    ////////////////////////////////////////
    always @(posedge mclk) begin
        if (meas_start === 1'b1) starts++;
        if (meas_done === 1'b1) last_val <= meas_value;
        if (rd_ev) begin
            e = exp_q.pop_front();
            n = name_q.pop_front();
            `CHK(n, e, rd_seen)
        end
    end
    ////////////////////////////////////////
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat);
        int k;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 50) begin
            fail_count++;
            close_out();
        end
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, a, wd, dummy);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        exp_q.push_back(ex);
        name_q.push_back(nm);
        rd_seen <= d;
        rd_ev <= 1'b1;
        @(posedge mclk);
        rd_ev <= 1'b0;
    endtask
    task automatic wait_starts(input int want, input int lim);
        for (int k = 0; k < lim && starts < want; k++) @(posedge mclk);
        if (starts < want) begin
            `CHK("starts", want, starts)
            close_out();
        end
    endtask
    task automatic steps(input logic dir, input int cnt);
        repeat (cnt) begin
            step_dir <= dir;
            step_go <= 1'b1;
            encoder_reference <= ~encoder_reference;
            @(posedge mclk);
            step_go <= 1'b0;
            repeat (20) @(posedge mclk);
        end
    endtask
    task automatic poll();
        int k;
        for (k = 0; k < 100; k++) begin
            bus(1'b0, ADDR_PSTAT, 32'h0, got);
            if ((got & 32'h5) != 32'h0) break;
        end
        if (k == 100) begin
            fail_count++;
            close_out();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(ADDR_STEP, {16'h0, RESET_STEP}, "step reset");
        rd(ADDR_INTERVAL, RESET_INTERVAL, "interval reset");
        rd(8'h40, 32'h0, "unmapped");
        `CHK("laser_reduced", 1'b1, laser_reduced)
        // Pin rests low past the minimum before the first edge
        repeat (LOW_MIN_CYC + 100) @(posedge mclk);
        lag <= 8'd30;
        wr(ADDR_CTRL, 32'h4);
        trigger_in <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK("outputs_frozen", 1'b1, outputs_frozen)
        s0 = starts;
        trigger_in <= 1'b0;
        wait_starts(s0 + 1, TRIG_DELAY_CYC);
        repeat (60) @(posedge mclk);
        `CHK("starts", s0 + 1, starts)
        `CHK("outputs_frozen", 1'b0, outputs_frozen)
        rd(ADDR_RESULT, last_val, "result");
        `CHK("result_value", last_val, result_value)
        s0 = starts;
        wr(ADDR_CTRL, 32'hc);
        wr(ADDR_CTRL, 32'hc);
        wr(ADDR_CTRL, 32'hc);
        repeat (150) @(posedge mclk);
        `CHK("starts", s0 + 2, starts)
        lag <= 8'd1;
        s0 = starts;
        wr(ADDR_CTRL, 32'h8);
        repeat (50) @(posedge mclk);
        `CHK("starts", s0, starts)
        trigger_in <= 1'b1;
        wr(ADDR_CTRL, 32'h5);
        repeat (20) @(posedge mclk);
        s0 = starts;
        repeat (100) @(posedge mclk);
        `CHK("starts", s0, starts)
        trigger_in <= 1'b0;
        wait_starts(s0 + 3, 500);
        iv = 16 + ($unsigned($random(seed)) % 32);
        wr(ADDR_INTERVAL, iv);
        wr(ADDR_CTRL, 32'h6);
        repeat (50) @(posedge mclk);
        s0 = starts;
        repeat (40 * (iv + 1)) @(posedge mclk);
        `CHK("interval starts", 1'b1, (starts - s0) inside {[39:41]})
        wr(ADDR_STEP, 32'h2);
        rd(ADDR_STEP, 32'h3, "step floor");
        wr(ADDR_STEP, 32'h4);
        rd(ADDR_STEP, 32'h4, "step");
        wr(ADDR_CTRL, 32'h7);
        bus(1'b0, ADDR_ENC_POS, 32'h0, p0);
        s0 = starts;
        steps(1'b0, 8);
        `CHK("encoder starts", s0 + 2, starts)
        bus(1'b0, ADDR_ENC_POS, 32'h0, got);
        `CHK("enc distance", 1'b1, (got - p0 == 32'h8) || (p0 - got == 32'h8))
        steps(1'b1, 8);
        rd(ADDR_ENC_POS, p0, "enc return");
        for (int i = 0; i < 4; i++) begin
            config_locked <= (i == 1);
            wr(ADDR_SEL, (i == 3) ? 32'h1 : 32'h0);
            wr(ADDR_ARG, ld_arg[i]);
            wr(ADDR_PSTAT, 32'h0);
            wr(ADDR_CTRL, 32'h10);
            poll();
            rd(ADDR_PSTAT, ld_st[i], "load status");
            rd(ADDR_RET_ARG, ld_ret[i], "load return");
            `CHK("active_setup", 16'h2, active_setup)
        end
        close_out();
    end
endmodule // testbench
